//--- include/tiu_pkg.sv
// Package: register map, field layout, reset values and carriers of the timer and interrupt unit
package tiu_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_TIMER_MODE = 8'hF1;
    localparam logic [7:0] ADDR_CNT_B = 8'hF2;
    localparam logic [7:0] ADDR_DIV_B = 8'hF3;
    localparam logic [7:0] ADDR_CNT_A = 8'hF4;
    localparam logic [7:0] ADDR_DIV_A = 8'hF5;
    localparam logic [7:0] ADDR_PORT3_MODE = 8'hF7;
    localparam logic [7:0] ADDR_INT_PRIO = 8'hF9;
    localparam logic [7:0] ADDR_INT_REQ = 8'hFA;
    localparam logic [7:0] ADDR_INT_MASK = 8'hFB;
    // Reset values
    localparam logic [7:0] TIMER_MODE_RST = 8'h00;
    localparam logic [7:0] PORT3_MODE_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // Timer mode fields
    localparam int TM_LOAD_A = 0;
    localparam int TM_EN_A = 1;
    localparam int TM_LOAD_B = 2;
    localparam int TM_EN_B = 3;
    localparam int TM_IN_LSB = 4;
    // Divider fields: bit0 continuous, bit1 ext clock (B), bits 7:2 divisor
    localparam int DIV_CONT = 0;
    localparam int DIV_EXT = 1;
    localparam int DIV_LSB = 2;
    // Interrupt mask global enable bit
    localparam int MASK_GLOBAL = 7;
    localparam int NUM_IRQ = 6;
    // Internal clock divided by four for counters A and B
    localparam logic [1:0] INT_DIV4_LAST = 2'h3;
    // Input line use modes for in_line1
    typedef enum logic [1:0] {
        TIU_IN_EXTCLK = 2'h0,
        TIU_IN_GATE = 2'h1,
        TIU_IN_NRETRIG = 2'h2,
        TIU_IN_RETRIG = 2'h3
    } tiu_in_mode_type;
    // Register bus carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tiu_bus_type;
    // Grant carrier
    typedef struct packed {
        logic valid;
        logic [2:0] src;
        logic [7:0] vector;
    } tiu_grant_type;
endpackage

//--- logic/tiu_divider.sv
// Programmable 6-bit divider, 1 to 64, emitting one pulse per divided period
`timescale 1ns/1ps
`default_nettype none
module tiu_divider (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic tick,
    input wire logic [5:0] divisor,
    output logic pulse
);
    // Down count; divisor 0 means 64
    logic [5:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Divide the tick stream
    always_ff @(posedge clk)
    begin
        if (sys_rst || restart)
        begin
            cnt_r <= divisor - 6'h01;
        end
        else if (tick)
        begin
            // End of count reloads
            if (cnt_r == 6'h00)
                cnt_r <= divisor - 6'h01;
            else
                cnt_r <= cnt_r - 6'h01;
        end
    end

    // Pulse on end of divider count
    assign pulse = tick && (cnt_r == 6'h00);
endmodule
`default_nettype wire

//--- logic/tiu_counter.sv
// 8-bit down-counter with single-pass and modulo-N modes
`timescale 1ns/1ps
`default_nettype none
module tiu_counter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic enable,
    input wire logic cont,
    input wire logic dec,
    input wire logic wr_init,
    input wire logic [7:0] init,
    output logic [7:0] count,
    output logic done,
    output logic running
);
    // Initial value, 0 means 256
    logic [7:0] init_r;
    logic [7:0] count_r;
    logic run_r;

    ////////////////////////////////////////////////////////////////////////
    // Hold initial value
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            init_r <= 8'h00;
        else if (wr_init)
            init_r <= init;
    end

    // Count down, reload or halt at end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_r <= 8'h00;
            run_r <= 1'b0;
        end
        else if (load)
        begin
            // Restart from initial value
            count_r <= wr_init ? init : init_r;
            run_r <= 1'b1;
        end
        else if (!enable)
        begin
            run_r <= 1'b0;
        end
        else if (dec && run_r)
        begin
            if (count_r == 8'h01)
            begin
                // Modulo-N reloads, single pass halts
                count_r <= cont ? init_r : 8'h00;
                run_r <= cont;
            end
            else
                count_r <= count_r - 8'h01;
        end
        else if (!run_r && enable && count_r != 8'h00)
            run_r <= 1'b1; // resume from current value
    end

    assign count = count_r;
    assign running = run_r;
    assign done = dec && run_r && enable && !load && count_r == 8'h01;
endmodule
`default_nettype wire

//--- logic/tiu_top.sv
// Timer and interrupt unit: two counters with dividers and vectored interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tiu_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stop_wake_pin,
    input wire logic low_noise,
    input wire logic halted,
    input wire tiu_pkg::tiu_bus_type bus,
    input wire logic int_ack,
    input wire logic in_line1,
    input wire logic in_line2,
    input wire logic in_line3,
    input wire logic analog_in_one,
    input wire logic analog_in_two,
    input wire logic analog_ref,
    output logic [7:0] rdata,
    output logic int_req,
    output tiu_pkg::tiu_grant_type grant,
    output logic save_context,
    output logic halt_wake
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] timer_mode_r; // Timer mode control
    logic [7:0] div_a_r; // Counter A divider (write only)
    logic [7:0] div_b_r; // Counter B divider (write only)
    logic [7:0] port3_mode_r; // Port 3 mode
    logic [7:0] prio_r; // Priority select
    logic [5:0] req_r; // Pending requests
    logic [7:0] mask_r; // Enables
    logic [7:0] rdata_r;
    logic int_req_r;
    tiu_pkg::tiu_grant_type grant_r;
    logic save_r;
    logic wake_r;
    // Synchronisers and edge history
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] prev_r;
    // Internal timer tick divider
    logic half_r;
    logic [1:0] quarter_r;
    logic timer_clock_internal_tick;
    logic int_div4_tick;
    // Counter plumbing
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic done_a;
    logic done_b;
    logic run_a;
    logic run_b;
    logic pulse_a;
    logic pulse_b;
    logic tick_b;
    logic trig_load_b;
    logic wr_a;
    logic wr_b;
    logic load_a;
    logic load_b;
    logic [5:0] events;
    logic [5:0] pend;
    logic [2:0] pick;
    logic pick_valid;
    tiu_pkg::tiu_in_mode_type in_mode;
    logic [2:0] digital;
    logic [2:0] fall;
    logic rise2;
    logic ext_tick;

    ////////////////////////////////////////////////////////////////////////
    // Bus write of configuration; stop-wake does not touch these
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // Full reset restores defaults
            timer_mode_r <= tiu_pkg::TIMER_MODE_RST;
            port3_mode_r <= tiu_pkg::PORT3_MODE_RST;
            div_a_r <= tiu_pkg::DIV_RST;
            div_b_r <= tiu_pkg::DIV_RST;
            prio_r <= 8'h00;
        end
        else
        begin
            // Load bits are one-shot commands, even while other registers are written
            timer_mode_r[tiu_pkg::TM_LOAD_A] <= 1'b0;
            timer_mode_r[tiu_pkg::TM_LOAD_B] <= 1'b0;
            if (bus.wr)
            begin
                // Register decode; a mode write overrides the clear above
                unique case (bus.addr)
                    tiu_pkg::ADDR_TIMER_MODE: timer_mode_r <= bus.wdata;
                    tiu_pkg::ADDR_DIV_A: div_a_r <= bus.wdata;
                    tiu_pkg::ADDR_DIV_B: div_b_r <= bus.wdata;
                    tiu_pkg::ADDR_PORT3_MODE: port3_mode_r <= bus.wdata;
                    tiu_pkg::ADDR_INT_PRIO: prio_r <= bus.wdata;
                    default: prio_r <= prio_r;
                endcase
            end
        end
    end

    // Read mux; dividers read as zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdata_r <= 8'h00;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                tiu_pkg::ADDR_TIMER_MODE: rdata_r <= timer_mode_r;
                tiu_pkg::ADDR_CNT_A: rdata_r <= cnt_a;
                tiu_pkg::ADDR_CNT_B: rdata_r <= cnt_b;
                tiu_pkg::ADDR_PORT3_MODE: rdata_r <= port3_mode_r;
                tiu_pkg::ADDR_INT_PRIO: rdata_r <= prio_r;
                tiu_pkg::ADDR_INT_REQ: rdata_r <= {2'h0, req_r};
                tiu_pkg::ADDR_INT_MASK: rdata_r <= mask_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port 3 synchronisers, analog select muxes the comparator outputs
    assign digital = port3_mode_r[1] ? {analog_ref, in_line2, in_line1} :
        {in_line3, in_line2, in_line1};

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= 3'h7;
            sync_r <= 3'h7;
            prev_r <= 3'h7;
        end
        else
        begin
            // Two flops then edge history
            meta_r <= port3_mode_r[0] ? {analog_ref, analog_in_two, analog_in_one} : digital;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign fall = prev_r & ~sync_r;
    assign rise2 = ~prev_r[1] & sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Internal timer tick: halved crystal, or full rate in low noise
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            half_r <= 1'b0;
        else
            half_r <= ~half_r;
    end

    assign timer_clock_internal_tick = low_noise | half_r;

    // Divide by four for the internal source of counters A and B
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            quarter_r <= 2'h0;
        else if (timer_clock_internal_tick)
            quarter_r <= quarter_r + 2'h1;
    end

    assign int_div4_tick = timer_clock_internal_tick && quarter_r == tiu_pkg::INT_DIV4_LAST;

    ////////////////////////////////////////////////////////////////////////
    // in_line1 use for counter B
    assign in_mode = tiu_pkg::tiu_in_mode_type'(timer_mode_r[tiu_pkg::TM_IN_LSB +: 2]);
    assign ext_tick = fall[0];

    always_comb
    begin
        tick_b = int_div4_tick;
        trig_load_b = 1'b0;
        unique case (in_mode)
            tiu_pkg::TIU_IN_EXTCLK: tick_b = div_b_r[tiu_pkg::DIV_EXT] ? ext_tick : int_div4_tick;
            tiu_pkg::TIU_IN_GATE: tick_b = int_div4_tick && sync_r[0];
            tiu_pkg::TIU_IN_NRETRIG: trig_load_b = ext_tick && !run_b;
            tiu_pkg::TIU_IN_RETRIG: trig_load_b = ext_tick;
        endcase
    end

    assign wr_a = bus.wr && bus.addr == tiu_pkg::ADDR_CNT_A;
    assign wr_b = bus.wr && bus.addr == tiu_pkg::ADDR_CNT_B;
    assign load_a = timer_mode_r[tiu_pkg::TM_LOAD_A];
    assign load_b = timer_mode_r[tiu_pkg::TM_LOAD_B] || trig_load_b;

    // Counter A: internal source only
    tiu_divider u_div_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(load_a),
        .tick(int_div4_tick),
        .divisor(div_a_r[7:tiu_pkg::DIV_LSB]),
        .pulse(pulse_a)
    );

    tiu_counter u_cnt_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(load_a),
        .enable(timer_mode_r[tiu_pkg::TM_EN_A]),
        .cont(div_a_r[tiu_pkg::DIV_CONT]),
        .dec(pulse_a),
        .wr_init(wr_a),
        .init(bus.wdata),
        .count(cnt_a),
        .done(done_a),
        .running(run_a)
    );

    // Counter B
    tiu_divider u_div_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(load_b),
        .tick(tick_b),
        .divisor(div_b_r[7:tiu_pkg::DIV_LSB]),
        .pulse(pulse_b)
    );

    tiu_counter u_cnt_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(load_b),
        .enable(timer_mode_r[tiu_pkg::TM_EN_B] || in_mode == tiu_pkg::TIU_IN_NRETRIG || in_mode == tiu_pkg::TIU_IN_RETRIG),
        .cont(div_b_r[tiu_pkg::DIV_CONT]),
        .dec(pulse_b),
        .wr_init(wr_b),
        .init(bus.wdata),
        .count(cnt_b),
        .done(done_b),
        .running(run_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event order matches request bits 0..5
    assign events = {done_b, done_a, rise2, fall[0], fall[2], fall[1]};

    // Request register: set wins over grant clear and software write
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            req_r <= 6'h00;
        else if (bus.wr && bus.addr == tiu_pkg::ADDR_INT_REQ)
            req_r <= bus.wdata[5:0] | events;
        else if (grant_r.valid)
            req_r <= (req_r & ~(6'h01 << grant_r.src)) | events;
        else
            req_r <= req_r | events;
    end

    // Mask register; grant drops global enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mask_r <= 8'h00;
        else if (bus.wr && bus.addr == tiu_pkg::ADDR_INT_MASK)
            mask_r <= bus.wdata;
        else if (grant_r.valid)
            mask_r[tiu_pkg::MASK_GLOBAL] <= 1'b0;
    end

    assign pend = req_r & mask_r[5:0] & {6{mask_r[tiu_pkg::MASK_GLOBAL]}};

    // Priority encoder: rotated search starting at priority field
    always_comb
    begin
        logic [2:0] idx;
        idx = 3'h0;
        pick = 3'h0;
        pick_valid = 1'b0;
        for (int i = 5; i >= 0; i--)
        begin
            idx = 3'((int'(prio_r[2:0]) + i) % tiu_pkg::NUM_IRQ);
            if (pend[idx])
            begin
                pick = idx;
                pick_valid = 1'b1;
            end
        end
    end

    // Request output and vectored grant
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            int_req_r <= 1'b0;
            grant_r <= '0;
            save_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            int_req_r <= pick_valid && !grant_r.valid;
            grant_r.valid <= int_ack && int_req_r && pick_valid;
            grant_r.src <= pick;
            grant_r.vector <= {4'h0, pick, 1'b0};
            save_r <= int_ack && int_req_r && pick_valid;
            wake_r <= halted && int_ack && int_req_r && pick_valid;
        end
    end

    assign rdata = rdata_r;
    assign int_req = int_req_r;
    assign grant = grant_r;
    assign save_context = save_r;
    assign halt_wake = wake_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_GRANT_CLEARS_GLOBAL: assert property (@(posedge clk) disable iff (sys_rst)
        grant_r.valid && !bus.wr |=> !mask_r[tiu_pkg::MASK_GLOBAL]) else $error("grant left global on");
    AST_VECTOR_PAIR: assert property (@(posedge clk) disable iff (sys_rst)
        grant_r.valid |-> grant_r.vector == {4'h0, grant_r.src, 1'b0}) else $error("bad vector");
    AST_MASKED_NO_REQ: assert property (@(posedge clk) disable iff (sys_rst)
        !mask_r[tiu_pkg::MASK_GLOBAL] |=> !int_req_r) else $error("masked request raised");
    AST_EVENT_SETS: assert property (@(posedge clk) disable iff (sys_rst)
        events[4] |=> req_r[4]) else $error("event lost");
    AST_FALL_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sync_r[1]) |=> req_r[0]) else $error("fall not caught");
    AST_RESET_CLEAR: assert property (@(posedge clk) $past(sys_rst) |-> req_r == 6'h00 &&
        timer_mode_r == 8'h00) else $error("reset values wrong");
    AST_CNT_DONE: assert property (@(posedge clk) disable iff (sys_rst)
        done_a |-> cnt_a == 8'h01 && pulse_a) else $error("done without end");
    AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
        halt_wake |-> grant_r.valid) else $error("wake without grant");
    AST_DIV4: assert property (@(posedge clk) disable iff (sys_rst)
        int_div4_tick |=> !int_div4_tick) else $error("div4 too fast");
    COV_GRANT: cover property (@(posedge clk) grant_r.valid);
    COV_DONE_B: cover property (@(posedge clk) done_b);
    COV_RISE: cover property (@(posedge clk) rise2);
endmodule
`default_nettype wire

//--- verif/tiu_core_model.sv
// Processor core stand-in: answers interrupt requests and records grants
`timescale 1ns/1ps
`default_nettype none
module tiu_core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic int_req,
    input wire tiu_pkg::tiu_grant_type grant,
    input wire logic halt_wake,
    input wire logic [3:0] ack_delay,
    output logic int_ack,
    output logic [7:0] last_vec,
    output logic [2:0] last_src,
    output int grants,
    output int wakes
);
    // Cycles that the request has stood unanswered
    logic [3:0] wait_r;
    // Machine cycle issued, grant still outstanding
    logic busy_r;
    ////////////////////////////////////////////////////////////////
    // Machine cycle only after the request stood a chosen delay
    always_ff @(posedge clk)
    begin
        int_ack <= 1'b0;
        if (sys_rst)
        begin
            wait_r <= 4'h0;
            busy_r <= 1'b0;
        end
        else if (!int_req || busy_r)
        begin
            wait_r <= 4'h0;
        end
        else if (wait_r >= ack_delay)
        begin
            int_ack <= 1'b1;
            busy_r <= 1'b1;
            wait_r <= 4'h0;
        end
        else
        begin
            wait_r <= wait_r + 4'h1;
        end
        // Grant closes the machine cycle
        if (grant.valid)
        begin
            busy_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Record of branch targets and wake-ups
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            last_vec <= 8'h00;
            last_src <= 3'h0;
            grants <= 0;
            wakes <= 0;
        end
        else
        begin
            // Vector fetched on grant
            if (grant.valid)
            begin
                last_vec <= grant.vector;
                last_src <= grant.src;
                grants <= grants + 1;
            end
            // Halt left on an interrupt
            if (halt_wake)
            begin
                wakes <= wakes + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tiu_top_tb.sv
// Self-checking bench for the timer and interrupt unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tiu_top_tb;
    logic clk;
    logic sys_rst;
    logic low_noise;
    logic halted;
    // Lines one to three, idle high
    logic [2:0] in_lines;
    logic int_ack;
    logic int_req;
    logic [7:0] rdata;
    // Last value read back
    logic [7:0] rv;
    logic [3:0] ack_delay;
    logic [7:0] last_vec;
    logic [2:0] last_src;
    int grants;
    int wakes;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    tiu_pkg::tiu_bus_type bus;
    tiu_pkg::tiu_grant_type grant;
    logic halt_wake;
    // Context-save pulses seen
    logic save_ctx;
    int saves = 0;
    ////////////////////////////////////////////////////////////////
    // Device and core model
    tiu_top dut_u (.clk(clk), .sys_rst(sys_rst), .stop_wake_pin(1'b1), .low_noise(low_noise),
        .halted(halted), .bus(bus), .int_ack(int_ack), .in_line1(in_lines[0]), .in_line2(in_lines[1]),
        .in_line3(in_lines[2]), .analog_in_one(1'b0), .analog_in_two(1'b0), .analog_ref(1'b0),
        .rdata(rdata), .int_req(int_req), .grant(grant), .save_context(save_ctx), .halt_wake(halt_wake));
    tiu_core_model core_u (.clk(clk), .sys_rst(sys_rst), .int_req(int_req), .grant(grant),
        .halt_wake(halt_wake), .ack_delay(ack_delay), .int_ack(int_ack), .last_vec(last_vec),
        .last_src(last_src), .grants(grants), .wakes(wakes));
    ////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (save_ctx)
            saves <= saves + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
    endtask
    // Register read, data the cycle after
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        rv = rdata;
    endtask
    // Bounded wait for a grant count
    task automatic wait_grant(input int n);
        int k;
        k = 0;
        while (grants < n && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        `CHK("grants", n, grants)
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset values, refused reads, second reset
    task automatic t_reset();
        rd(tiu_pkg::ADDR_TIMER_MODE);
        `CHK("mode rst", 8'h00, rv)
        rd(tiu_pkg::ADDR_INT_REQ);
        `CHK("req rst", 6'h00, rv[5:0])
        rd(tiu_pkg::ADDR_INT_MASK);
        `CHK("global rst", 1'b0, rv[7])
        rd(tiu_pkg::ADDR_DIV_A);
        `CHK("divider hidden", 8'h00, rv)
        wr(8'hF0, 8'h5A);
        rd(8'hF0);
        `CHK("unmapped", 8'h00, rv)
        wr(tiu_pkg::ADDR_PORT3_MODE, 8'h01);
        rd(tiu_pkg::ADDR_PORT3_MODE);
        `CHK("port3 mode", 8'h01, rv)
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h30);
        rd(tiu_pkg::ADDR_TIMER_MODE);
        `CHK("line use", 2'h3, rv[5:4])
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(tiu_pkg::ADDR_TIMER_MODE);
        `CHK("mode rst2", 8'h00, rv)
        rd(tiu_pkg::ADDR_PORT3_MODE);
        `CHK("port3 rst", 2'h0, rv[1:0])
        $display("test reset done");
    endtask
    // Each pin edge serviced through its own vector, from halt
    task automatic t_edges();
        int s;
        halted <= 1'b1;
        wr(tiu_pkg::ADDR_INT_PRIO, 8'h00);
        for (s = 0; s < 4; s++)
        begin
            wr(tiu_pkg::ADDR_INT_MASK, 8'hBF);
            @(posedge clk);
            in_lines[(s == 1) ? 2 : (s == 2) ? 0 : 1] <= (s == 3);
            wait_grant(grants + 1);
            `CHK("edge vector", 8'(2 * s), last_vec)
            `CHK("edge source", 3'(s), last_src)
            repeat (10) @(posedge clk);
            rd(tiu_pkg::ADDR_INT_REQ);
            `CHK("req cleared", 6'h00, rv[5:0])
            rd(tiu_pkg::ADDR_INT_MASK);
            `CHK("global off", 1'b0, rv[7])
        end
        `CHK("woken", 1'b1, wakes > 0)
        halted <= 1'b0;
        // Lines back to idle high; rises on lines one and three raise nothing
        in_lines <= 3'h7;
        $display("test edges done");
    endtask
    // Counter A single pass, polled, timed
    task automatic t_count_a();
        int t0;
        int k;
        wr(tiu_pkg::ADDR_INT_MASK, 8'h00);
        wr(tiu_pkg::ADDR_INT_REQ, 8'h00);
        wr(tiu_pkg::ADDR_DIV_A, 8'h0C);
        wr(tiu_pkg::ADDR_CNT_A, 8'h02);
        t0 = cyc;
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h03);
        k = 0;
        rv = 8'h00;
        while (rv[4] !== 1'b1 && k < 100)
        begin
            rd(tiu_pkg::ADDR_INT_REQ);
            k++;
        end
        `CHK("a period", 1'b1, (cyc - t0 >= 20) && (cyc - t0 <= 31))
        `CHK("masked", 1'b0, int_req)
        wr(tiu_pkg::ADDR_INT_REQ, 8'h00);
        repeat (60) @(posedge clk);
        rd(tiu_pkg::ADDR_INT_REQ);
        `CHK("single pass", 1'b0, rv[4])
        rd(tiu_pkg::ADDR_CNT_A);
        `CHK("a halted", 8'h00, rv)
        $display("test counter a done");
    endtask
    // Counter B modulo-N, stop, resume
    task automatic t_cont_b();
        int k;
        logic [7:0] held;
        low_noise <= 1'b0;
        ack_delay <= 4'h9;
        wr(tiu_pkg::ADDR_DIV_B, 8'h05);
        wr(tiu_pkg::ADDR_CNT_B, 8'h02);
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h0C);
        for (k = 0; k < 2; k++)
        begin
            wr(tiu_pkg::ADDR_INT_MASK, 8'hA0);
            wait_grant(grants + 1);
            `CHK("b vector", 8'h0A, last_vec)
        end
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h00);
        rd(tiu_pkg::ADDR_CNT_B);
        held = rv;
        repeat (40) @(posedge clk);
        rd(tiu_pkg::ADDR_CNT_B);
        `CHK("stopped", held, rv)
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h08);
        // One step shows within a divided period; count alternates 2,1
        k = 0;
        while (rv === held && k < 12)
        begin
            rd(tiu_pkg::ADDR_CNT_B);
            k++;
        end
        `CHK("resumed", 1'b1, rv !== held)
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h00);
        low_noise <= 1'b1;
        $display("test counter b done");
    endtask
    // Counter B clocked from line one, one slow legal pulse
    task automatic t_ext();
        wr(tiu_pkg::ADDR_INT_MASK, 8'h00);
        wr(tiu_pkg::ADDR_DIV_B, 8'h07);
        wr(tiu_pkg::ADDR_CNT_B, 8'h02);
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h0C);
        repeat (50) @(posedge clk);
        rd(tiu_pkg::ADDR_CNT_B);
        `CHK("no ext clock", 8'h02, rv)
        in_lines[0] <= 1'b0;
        repeat (10) @(posedge clk);
        in_lines[0] <= 1'b1;
        repeat (10) @(posedge clk);
        rd(tiu_pkg::ADDR_CNT_B);
        `CHK("one ext tick", 8'h01, rv)
        wr(tiu_pkg::ADDR_TIMER_MODE, 8'h00);
        wr(tiu_pkg::ADDR_INT_REQ, 8'h00);
        $display("test external clock done");
    endtask
    // Software requests: masked hold, then priority order
    task automatic t_prio();
        int n;
        ack_delay <= 4'h4;
        n = grants;
        wr(tiu_pkg::ADDR_INT_REQ, 8'h0A);
        repeat (20) @(posedge clk);
        `CHK("masked held", n, grants)
        rd(tiu_pkg::ADDR_INT_REQ);
        `CHK("polled", 6'h0A, rv[5:0])
        wr(tiu_pkg::ADDR_INT_MASK, 8'h8A);
        wait_grant(n + 1);
        `CHK("first", 8'h02, last_vec)
        wr(tiu_pkg::ADDR_INT_MASK, 8'h8A);
        wait_grant(n + 2);
        `CHK("second", 8'h06, last_vec)
        // Rotation starting at source two puts source three ahead of one
        wr(tiu_pkg::ADDR_INT_PRIO, 8'h02);
        wr(tiu_pkg::ADDR_INT_REQ, 8'h0A);
        wr(tiu_pkg::ADDR_INT_MASK, 8'h8A);
        wait_grant(n + 3);
        `CHK("rotated", 8'h06, last_vec)
        `CHK("saves", grants, saves)
        $display("test priority done");
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        low_noise = 1'b1;
        halted = 1'b0;
        in_lines = 3'h7;
        bus = '0;
        ack_delay = 4'h4;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_edges();
        t_count_a();
        t_cont_b();
        t_ext();
        t_prio();
        stop_test();
    end
endmodule
`default_nettype wire
